// *** rtl/prs_top.sv ***
// Purpose: Host read path, latch readback, even/odd plane decode and serializer
// Assumes: All inputs synchronous to clk_sys; plane data valid with fb_rd
// Notes:   Write modes and memory map decode sit in other blocks

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Read mode 0 returns selected plane byte
// - Even/odd ignores plane select low bit
// - Chain-four ignores both plane select bits
// - Plane select also picks latch readback
// - Shift control picks serializer format
// - Format 00: bit per plane, MSB first
// - Format 01: planes 0/2 pairs, then 1/3
// - Format 1x: nibbles, plane 0 to 3
// - Even/odd bit steers plane enables by A0
// - Read mode bit clear returns plane data
// - Read mode bit set returns compare result
// - Don't-care zero excludes plane from compare
// - Every host read loads all four latches
module prs_top
   import prs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Host register port
   input  wire logic        io_wr,
   input  wire logic        io_rd,
   input  wire logic        io_sel_data,
   input  wire logic [7:0]  io_wdata,
   output logic      [7:0]  io_rdata,
   output logic             io_rvalid,
   // Settings held by neighbouring register blocks
   input  wire logic [3:0]  color_compare,
   input  wire logic [3:0]  color_ignore,
   input  wire logic [3:0]  plane_mask,
   input  wire logic        chain_four,
   // Host frame buffer read
   input  wire logic        fb_rd,
   input  wire logic [1:0]  fb_addr_lo,
   input  wire prs_planes_t fb_plane_data,
   output logic      [7:0]  fb_rdata,
   output logic             fb_rvalid,
   output logic      [3:0]  plane_enable,
   output logic      [7:0]  latch_readback,
   // Display serializer
   input  wire logic        shift_load,
   input  wire prs_planes_t shift_planes,
   output logic      [3:0]  pix_out,
   output logic             pix_valid
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic        [7:0] index_q;
   logic        [7:0] plane_sel_q;
   prs_mode_s         mode_q;
   logic        [7:0] io_rdata_q;
   logic              io_rvalid_q;
   prs_planes_t       latch_q;
   logic        [7:0] fb_rdata_q;
   logic              fb_rvalid_q;
   logic        [3:0] plane_en_q;
   logic        [7:0] latch_rb_q;
   prs_planes_t       shift_q;
   logic        [2:0] xfer_q;
   logic        [2:0] xfer_d;
   prs_state_e        state_q;
   prs_state_e        state_d;
   logic        [3:0] pix_q;
   logic              pix_valid_q;

   ////////////////////////////////////////////////////////////////////////////
   // Nibble for one transfer in the chosen format
   function automatic logic [3:0] prs_serial(input logic [1:0] ctl,
                                             input prs_planes_t pl,
                                             input logic [2:0] k);
      logic [2:0] bpos;
      logic [3:0] res;
      bpos = 3'(PRS_LAST_XFER - k);
      res  = 4'h0;
      if (ctl == PRS_SHIFT_BIT) begin
         for (int p = 0; p < 4; p++) begin
            res[p] = pl[p][bpos];
         end
      end else if (ctl == PRS_SHIFT_PAIR) begin
         res = {pl[{1'b1, k[2]}][{~k[1:0], 1'b1}],
                pl[{1'b1, k[2]}][{~k[1:0], 1'b0}],
                pl[{1'b0, k[2]}][{~k[1:0], 1'b1}],
                pl[{1'b0, k[2]}][{~k[1:0], 1'b0}]};
      end else begin
         res = k[0] ? pl[k[2:1]][3:0] : pl[k[2:1]][7:4];
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Register port decode
   wire       wr_index  = io_wr & ~io_sel_data;
   wire       wr_data   = io_wr & io_sel_data;
   wire       hit_sel   = (index_q[3:0] == PRS_IDX_PLANE_SEL);
   wire       hit_mode  = (index_q[3:0] == PRS_IDX_MODE);
   wire [7:0] data_rd   = hit_sel  ? plane_sel_q :
                          hit_mode ? mode_q      : PRS_BYTE_ZERO;
   wire [7:0] io_rd_mux = io_sel_data ? data_rd : index_q;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         index_q <= PRS_IDX_RST;
      end else if (wr_index) begin
         index_q <= io_wdata & PRS_IDX_MASK;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         plane_sel_q <= PRS_PLANE_SEL_RST;
         mode_q      <= PRS_MODE_RST;
      end else if (wr_data) begin
         if (hit_sel) begin
            plane_sel_q <= io_wdata & PRS_PLANE_SEL_MASK;
         end
         if (hit_mode) begin
            mode_q <= io_wdata & PRS_MODE_MASK;
         end
      end
   end

   // Register read answer, one cycle after the strobe
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         io_rdata_q  <= PRS_BYTE_ZERO;
         io_rvalid_q <= 1'b0;
      end else begin
         io_rvalid_q <= io_rd;
         if (io_rd) begin
            io_rdata_q <= io_rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Plane choice for host reads
   // plane select picks plane; chain-four uses both address bits, even/odd uses A0 for bit 0
   wire [1:0] rd_plane = chain_four     ? fb_addr_lo :
                         mode_q.odd_even ? {plane_sel_q[1], fb_addr_lo[0]} :
                                           plane_sel_q[1:0];

   // bit set when included planes match
   logic [7:0] cmp_res;
   genvar gb;
   generate
      for (gb = 0; gb < 8; gb++) begin : g_cmp
         assign cmp_res[gb] = &(~color_ignore | ~({fb_plane_data[3][gb], fb_plane_data[2][gb],
                                                  fb_plane_data[1][gb], fb_plane_data[0][gb]}
                                                 ^ color_compare));
      end
   endgenerate

   // read mode picks plane data or compare
   wire [7:0] fb_rd_mux = mode_q.read_mode ? cmp_res : fb_plane_data[rd_plane];

   // even/odd steers planes by address bit 0
   wire [3:0] plane_en_d = mode_q.odd_even ?
                           (fb_addr_lo[0] ? PRS_ODD_PLANES : PRS_EVEN_PLANES) & plane_mask :
                           plane_mask;

   // Frame buffer read return and plane enables
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         fb_rdata_q  <= PRS_BYTE_ZERO;
         fb_rvalid_q <= 1'b0;
         plane_en_q  <= 4'h0;
      end else begin
         fb_rvalid_q <= fb_rd;
         plane_en_q  <= plane_en_d;
         if (fb_rd) begin
            fb_rdata_q <= fb_rd_mux;
         end
      end
   end

   // latches copy every plane on read
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latch_q <= '0;
      end else if (fb_rd) begin
         latch_q <= fb_plane_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latch_rb_q <= PRS_BYTE_ZERO;
      end else begin
         latch_rb_q <= latch_q[plane_sel_q[1:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serializer sequencing: eight transfers per load, reload restarts
   always_comb begin
      state_d = state_q;
      xfer_d  = xfer_q;
      case (state_q)
         PRS_ST_IDLE: begin
            if (shift_load) begin
               state_d = PRS_ST_SHIFT;
               xfer_d  = PRS_XFER_ZERO;
            end
         end
         PRS_ST_SHIFT: begin
            if (shift_load) begin
               xfer_d = PRS_XFER_ZERO;
            end else if (xfer_q == PRS_LAST_XFER) begin
               state_d = PRS_ST_IDLE;
            end else begin
               xfer_d = 3'(xfer_q + PRS_XFER_ONE);
            end
         end
         default: begin
            state_d = PRS_ST_IDLE;
            xfer_d  = PRS_XFER_ZERO;
         end
      endcase
   end

   // State and captured plane bytes
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= PRS_ST_IDLE;
         xfer_q  <= PRS_XFER_ZERO;
         shift_q <= '0;
      end else begin
         state_q <= state_d;
         xfer_q  <= xfer_d;
         if (shift_load) begin
            shift_q <= shift_planes;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pix_q       <= 4'h0;
         pix_valid_q <= 1'b0;
      end else begin
         pix_valid_q <= (state_q == PRS_ST_SHIFT) & ~shift_load;
         pix_q       <= prs_serial(mode_q.shift_ctl, shift_q, xfer_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign io_rdata       = io_rdata_q;
   assign io_rvalid      = io_rvalid_q;
   assign fb_rdata       = fb_rdata_q;
   assign fb_rvalid      = fb_rvalid_q;
   assign plane_enable   = plane_en_q;
   assign latch_readback = latch_rb_q;
   assign pix_out        = pix_q;
   assign pix_valid      = pix_valid_q;

endmodule

// *** rtl/prs_pkg.sv ***
// Purpose: Shared constants and types for the planar read and serializer block
// Assumes: Host reaches registers through an index port and a data port
// Notes:   All offsets, field masks and reset values live here

package prs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices written into the index port
   localparam logic [3:0] PRS_IDX_PLANE_SEL = 4'h4;   // read_plane_select
   localparam logic [3:0] PRS_IDX_MODE      = 4'h5;   // graphics_mode

   // Writable bits; every other bit is reserved and reads as zero
   localparam logic [7:0] PRS_IDX_MASK       = 8'h0F;
   localparam logic [7:0] PRS_PLANE_SEL_MASK = 8'h03;
   localparam logic [7:0] PRS_MODE_MASK      = 8'h7B;

   // Reset values
   localparam logic [7:0] PRS_IDX_RST       = 8'h00;
   localparam logic [7:0] PRS_PLANE_SEL_RST = 8'h00;
   localparam logic [7:0] PRS_MODE_RST      = 8'h00;
   localparam logic [7:0] PRS_BYTE_ZERO     = 8'h00;

   // Shift control encodings
   localparam logic [1:0] PRS_SHIFT_BIT  = 2'h0;
   localparam logic [1:0] PRS_SHIFT_PAIR = 2'h1;

   // Even/odd plane groups and serializer length
   localparam logic [3:0] PRS_EVEN_PLANES = 4'h5;
   localparam logic [3:0] PRS_ODD_PLANES  = 4'hA;
   localparam logic [2:0] PRS_LAST_XFER   = 3'h7;
   localparam logic [2:0] PRS_XFER_ZERO   = 3'h0;
   localparam logic [2:0] PRS_XFER_ONE    = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Four plane bytes, index is the plane number
   typedef logic [3:0][7:0] prs_planes_t;

   // Graphics mode register layout
   typedef struct packed {
      logic       rsv7;
      logic [1:0] shift_ctl;
      logic       odd_even;
      logic       read_mode;
      logic       rsv2;
      logic [1:0] write_mode;
   } prs_mode_s;

   // Serializer states
   typedef enum logic [1:0] {
      PRS_ST_IDLE  = 2'b01,
      PRS_ST_SHIFT = 2'b10
   } prs_state_e;

endpackage

// *** test/prs_checker.sv ***
// Purpose: Port assertions for prs_top
// Assumes: Mode register shadowed from host port writes
// Notes:   Bound from the bench top file
module prs_checker
   import prs_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        reset_n,
   // Host side
   input wire logic        io_wr,
   input wire logic        io_rd,
   input wire logic        io_sel_data,
   input wire logic [7:0]  io_wdata,
   input wire logic        io_rvalid,
   input wire logic [3:0]  color_ignore,
   input wire logic [3:0]  plane_mask,
   input wire logic        chain_four,
   input wire logic        fb_rd,
   input wire logic [1:0]  fb_addr_lo,
   input wire prs_planes_t fb_plane_data,
   input wire logic [7:0]  fb_rdata,
   input wire logic        fb_rvalid,
   input wire logic [3:0]  plane_enable,
   // Serializer
   input wire logic        shift_load,
   input wire logic        pix_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////
   // Shadow of index and mode registers
   logic [3:0] idx_q;
   logic [7:0] mode_q;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         idx_q  <= 4'h0;
         mode_q <= 8'h00;
      end else if (io_wr && !io_sel_data) begin
         idx_q <= io_wdata[3:0];
      end else if (io_wr && idx_q == PRS_IDX_MODE) begin
         mode_q <= io_wdata;
      end
   end
   ////////////////////////////////////////////////////////////
   chk_rd_answer: assert property (io_rd |=> io_rvalid)
      else $error("no read answer");
   chk_fb_answer: assert property (fb_rd |=> fb_rvalid)
      else $error("no frame answer");
   chk_chain_pick: assert property (fb_rd && chain_four && !mode_q[3]
      |=> fb_rdata == $past(fb_plane_data[fb_addr_lo])) else $error("chain plane wrong");
   chk_cmp_none: assert property (fb_rd && mode_q[3] && color_ignore == 4'h0
      |=> fb_rdata == 8'hFF) else $error("empty compare wrong");
   chk_even_odd: assert property ($past(reset_n) && $past(mode_q[4]) |-> plane_enable ==
      (($past(fb_addr_lo[0]) ? PRS_ODD_PLANES : PRS_EVEN_PLANES) & $past(plane_mask))) else $error("even odd wrong");
   chk_mask_only: assert property ($past(reset_n) && !$past(mode_q[4])
      |-> plane_enable == $past(plane_mask)) else $error("mask enable wrong");
   chk_load_start: assert property (shift_load ##1 !shift_load
      |-> !pix_valid ##1 pix_valid [*8]) else $error("stream start wrong");
   chk_eight_xfers: assert property (shift_load ##1 (!shift_load) [*8] ##1 !shift_load
      |=> !pix_valid) else $error("stream too long");
endmodule

// *** test/prs_host.sv ***
// Purpose: Host CPU model on the indexed register port
// Assumes: Drives on falling edges; answer one cycle after strobe
// Notes:   Bench calls the tasks by hierarchical name
module prs_host
   import prs_pkg::*;
(
   // Clock
   input  wire logic       clk_sys,
   // Register port
   output logic            io_wr,
   output logic            io_rd,
   output logic            io_sel_data,
   output logic      [7:0] io_wdata,
   input  wire logic [7:0] io_rdata,
   input  wire logic       io_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {io_wr, io_rd, io_sel_data, io_wdata} = 11'h000;
   end
   task automatic put_index(input logic [3:0] idx);
      @(negedge clk_sys);
      io_wr       = 1'b1;
      io_sel_data = 1'b0;
      io_wdata    = {4'h0, idx};
      @(negedge clk_sys);
   endtask
   // Write one register, then scramble the idle data bus
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      put_index(idx);
      io_sel_data = 1'b1;
      io_wdata    = d;
      @(negedge clk_sys);
      io_wr    = 1'b0;
      io_wdata = ~d;
   endtask
   // Read one register; no answer gives unknown data
   task automatic rd(input logic [3:0] idx, output logic [7:0] d);
      put_index(idx);
      io_wr       = 1'b0;
      io_rd       = 1'b1;
      io_sel_data = 1'b1;
      @(negedge clk_sys);
      io_rd = 1'b0;
      d     = io_rvalid ? io_rdata : 8'hXX;
   endtask
endmodule

// *** test/test_planar_read_and_serializer.sv ***
// Purpose: Self-checking bench for prs_top
// Assumes: Inputs driven on falling edges
// Notes:   Row loop for read paths, then serializer and reset
module test_planar_read_and_serializer
   import prs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] sel;
      logic [7:0] mode;
      logic       ch;
      logic [1:0] a;
      logic [3:0] cmp;
      logic [3:0] ign;
      logic [7:0] exp;
   } prs_row_s;
   logic        clk_sys = 1'b0;
   logic        reset_n, io_wr, io_rd, io_sel_data, io_rvalid, chain_four;
   logic        fb_rd, fb_rvalid, shift_load, pix_valid;
   logic [1:0]  fb_addr_lo;
   logic [3:0]  color_compare, color_ignore, plane_mask, plane_enable, pix_out;
   logic [7:0]  io_wdata, io_rdata, fb_rdata, latch_readback, v;
   prs_planes_t fb_plane_data = {8'hD3, 8'h6C, 8'hB5, 8'h1E};
   wire prs_planes_t shift_planes = fb_plane_data;
   int          err_total = 0;
   int          tests_run = 0;
   // Select, mode, chain, address, compare, include, result
   prs_row_s rows [10] = '{'{2'h0, 8'h00, 1'b0, 2'h0, 4'h0, 4'hF, 8'h1E},
      '{2'h1, 8'h00, 1'b0, 2'h0, 4'h0, 4'hF, 8'hB5}, '{2'h2, 8'h00, 1'b0, 2'h1, 4'h0, 4'hF, 8'h6C},
      '{2'h3, 8'h00, 1'b0, 2'h0, 4'h0, 4'hF, 8'hD3}, '{2'h3, 8'h10, 1'b0, 2'h0, 4'h0, 4'hF, 8'h6C},
      '{2'h2, 8'h10, 1'b0, 2'h1, 4'h0, 4'hF, 8'hD3}, '{2'h0, 8'h00, 1'b1, 2'h2, 4'h0, 4'hF, 8'h6C},
      '{2'h1, 8'h08, 1'b0, 2'h0, 4'h0, 4'h0, 8'hFF}, '{2'h3, 8'h08, 1'b0, 2'h0, 4'h0, 4'h3, 8'h40},
      '{2'h0, 8'h58, 1'b0, 2'h1, 4'h6, 4'h6, 8'h24}};
   always #2.5 clk_sys = ~clk_sys;
   prs_top u_dut (.*);
   prs_host u_host (.*);
   // Compare one byte and count it
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Expected serial nibble for format s, transfer k
   function automatic logic [3:0] xfer(input logic [1:0] s, input logic [2:0] k);
      logic [7:0] a;
      logic [7:0] b;
      if (s == 2'h0) return {fb_plane_data[3][~k], fb_plane_data[2][~k], fb_plane_data[1][~k], fb_plane_data[0][~k]};
      a = fb_plane_data[{1'b0, k[2]}] << {k[1:0], 1'b0};
      b = fb_plane_data[{1'b1, k[2]}] << {k[1:0], 1'b0};
      if (s == 2'h1) return {b[7:6], a[7:6]};
      a = fb_plane_data[k[2:1]];
      return k[0] ? a[3:0] : a[7:4];
   endfunction
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      end_of_test();
   end
   initial begin
      prs_row_s   r;
      logic [3:0] pe;
      {reset_n, fb_rd, shift_load, chain_four, fb_addr_lo} = 6'h00;
      {color_compare, color_ignore, plane_mask} = 12'h00D;
      repeat (8) @(negedge clk_sys);
      reset_n = 1'b1;
      u_host.rd(PRS_IDX_MODE, v);
      check(v, PRS_MODE_RST, "mode rst");
      u_host.wr(PRS_IDX_PLANE_SEL, 8'hFF);
      u_host.rd(PRS_IDX_PLANE_SEL, v);
      check(v, 8'h03, "sel bits");
      u_host.wr(PRS_IDX_MODE, 8'hFF);
      u_host.rd(PRS_IDX_MODE, v);
      check(v, 8'h7B, "mode bits");
      u_host.wr(4'h9, 8'hFF);
      u_host.rd(4'h9, v);
      check(v, 8'h00, "unmapped");
      $display("test registers done");
      for (int i = 0; i < 10; i++) begin
         r = rows[i];
         u_host.wr(PRS_IDX_PLANE_SEL, {6'h00, r.sel});
         u_host.wr(PRS_IDX_MODE, r.mode);
         {chain_four, fb_addr_lo, color_compare, color_ignore} = {r.ch, r.a, r.cmp, r.ign};
         fb_rd = 1'b1;
         @(negedge clk_sys);
         fb_rd = 1'b0;
         pe    = (r.mode[4] ? (r.a[0] ? 4'hA : 4'h5) : 4'hF) & plane_mask;
         check(fb_rdata, r.exp, "fb data");
         check({7'h00, fb_rvalid}, 8'h01, "fb valid");
         check({4'h0, plane_enable}, {4'h0, pe}, "enables");
         @(negedge clk_sys);
         check(latch_readback, fb_plane_data[r.sel], "latch");
      end
      u_host.wr(PRS_IDX_PLANE_SEL, 8'h03);
      @(negedge clk_sys);
      check(latch_readback, fb_plane_data[3], "latch sel");
      $display("test reads done");
      for (int s = 0; s < 4; s++) begin
         u_host.wr(PRS_IDX_MODE, {1'b0, s[1:0], 5'h00});
         shift_load = 1'b1;
         @(negedge clk_sys);
         shift_load = 1'b0;
         for (int k = 0; k < 8; k++) begin
            @(negedge clk_sys);
            check({3'h0, pix_valid, pix_out}, {4'h1, xfer(s[1:0], k[2:0])}, "pixel");
         end
         @(negedge clk_sys);
         check({7'h00, pix_valid}, 8'h00, "stream end");
      end
      $display("test serializer done");
      reset_n = 1'b0;
      @(negedge clk_sys);
      reset_n = 1'b1;
      check(latch_readback, 8'h00, "latch rst");
      $display("test reset done");
      end_of_test();
   end
endmodule
bind prs_top prs_checker u_chk (.*);
